// File: rtl/iwc_pkg.sv
// package: command layout, codes and timing for the low-power entry command
package iwc_pkg;
  localparam logic [7:0] IWC_CMD_IDLE = 8'h07;
  localparam logic [7:0] IWC_LEN_FULL = 8'h0E;
  localparam logic [7:0] IWC_RES_OK = 8'h00;
  localparam logic [7:0] IWC_RES_ERR = 8'h82;
  localparam logic [7:0] IWC_RES_LEN = 8'h01;
  localparam logic [7:0] IWC_ERR_LEN = 8'h00;
  // wake source mask bits
  localparam int IWC_SRC_TIMEOUT = 0;
  localparam int IWC_SRC_TAG = 1;
  localparam int IWC_SRC_PULSE = 3;
  localparam int IWC_SRC_SELECT = 4;
  localparam logic [7:0] IWC_SRC_TIMEOUT_CODE = 8'h01;
  localparam logic [7:0] IWC_SRC_TAG_CODE = 8'h02;
  localparam logic [7:0] IWC_SRC_PULSE_CODE = 8'h08;
  localparam logic [7:0] IWC_SRC_SELECT_CODE = 8'h10;
  // parameter byte indexes, counted after the length byte
  localparam logic [3:0] IWC_P_SRC = 4'h0;
  localparam logic [3:0] IWC_P_ENT_L = 4'h1;
  localparam logic [3:0] IWC_P_ENT_H = 4'h2;
  localparam logic [3:0] IWC_P_WAKE_L = 4'h3;
  localparam logic [3:0] IWC_P_WAKE_H = 4'h4;
  localparam logic [3:0] IWC_P_LEAVE_L = 4'h5;
  localparam logic [3:0] IWC_P_LEAVE_H = 4'h6;
  localparam logic [3:0] IWC_P_PERIOD = 4'h7;
  localparam logic [3:0] IWC_P_OSC = 4'h8;
  localparam logic [3:0] IWC_P_CONV = 4'h9;
  localparam logic [3:0] IWC_P_THR_LO = 4'hA;
  localparam logic [3:0] IWC_P_THR_HI = 4'hB;
  localparam logic [3:0] IWC_P_SWING = 4'hC;
  localparam logic [3:0] IWC_P_MAXSLEEP = 4'hD;
  localparam int IWC_NPARAM = 14;
  // resource control words
  localparam logic [15:0] IWC_ENT_HIBERNATE = 16'h0400;
  localparam logic [15:0] IWC_ENT_SLEEP = 16'h0100;
  localparam logic [15:0] IWC_ENT_CALIB = 16'hA200;
  localparam logic [15:0] IWC_ENT_TAG = 16'h2100;
  localparam logic [15:0] IWC_WAKE_HIBERNATE = 16'h0400;
  localparam logic [15:0] IWC_WAKE_SLEEP = 16'h3800;
  localparam logic [15:0] IWC_WAKE_CALIB = 16'hF801;
  localparam logic [15:0] IWC_WAKE_TAG = 16'h7901;
  localparam logic [15:0] IWC_LEAVE_ALL = 16'h1800;
  // recommended settings
  localparam logic [7:0] IWC_PERIOD_TYP = 8'h20;
  localparam logic [7:0] IWC_OSC_REC = 8'h60;
  localparam logic [7:0] IWC_CONV_REC = 8'h60;
  localparam logic [7:0] IWC_THR_LO_DEMO = 8'h64;
  localparam logic [7:0] IWC_THR_HI_DEMO = 8'h74;
  localparam logic [7:0] IWC_SWING_REC = 8'h3F;
  localparam logic [7:0] IWC_MAXSLEEP_MIN = 8'h00;
  localparam logic [7:0] IWC_MAXSLEEP_MAX = 8'h1F;
  localparam logic [7:0] IWC_MAXSLEEP_CAL = 8'h01;
  localparam logic [7:0] IWC_MAXSLEEP_TYP = 8'h08;
  // timing: one timeout unit is 256 slow periods
  localparam int IWC_TICKS_PER_UNIT = 256;
  localparam int IWC_PERIOD_BIAS = 2;
endpackage

// File: rtl/iwc_link_if.sv
// interface: byte command link between host and device
`timescale 1ns/1ps
interface iwc_link_if;
  logic [7:0] cmd_data;
  logic cmd_valid;
  logic cmd_ready;
  logic [7:0] rsp_data;
  logic rsp_valid;
  logic rsp_ready;
  logic wake_pulse_n;
  logic select_n;
  modport dev (input cmd_data, input cmd_valid, output cmd_ready,
    output rsp_data, output rsp_valid, input rsp_ready,
    input wake_pulse_n, input select_n);
  modport host (output cmd_data, output cmd_valid, input cmd_ready,
    input rsp_data, input rsp_valid, output rsp_ready,
    output wake_pulse_n, output select_n);
endinterface

// File: rtl/iwc_device.sv
// device end: decodes the low-power entry command and runs the wait-for-event state
`timescale 1ns/1ps
module iwc_device
  import iwc_pkg::*;
#(
  parameter int TICK_DIV = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  iwc_link_if.dev link,
  input wire logic [5:0] level_sample,
  output logic [15:0] resource_ctrl,
  output logic fast_osc_on,
  output logic conv_on,
  output logic carrier_on,
  output logic waiting
);
  import iwc_pkg::*;

  typedef enum logic [3:0] {
    IWC_S_CODE = 4'b0000,
    IWC_S_LEN = 4'b0001,
    IWC_S_PARAM = 4'b0010,
    IWC_S_IDLE = 4'b0011,
    IWC_S_OSC = 4'b0100,
    IWC_S_CONV = 4'b0101,
    IWC_S_BURST = 4'b0110,
    IWC_S_R0 = 4'b0111,
    IWC_S_R1 = 4'b1000,
    IWC_S_R2 = 4'b1001,
    IWC_S_DRAIN = 4'b1010
  } iwc_state_e;

  iwc_state_e state_ff;
  logic [7:0] prm_ff [IWC_NPARAM];
  logic [3:0] idx_ff;
  logic [7:0] rsp_src_ff;
  logic [7:0] tick_ff;
  logic [15:0] cnt_ff;
  logic [5:0] trials_ff;
  logic [7:0] unit_ff;
  logic entry_ff;
  logic len_bad_ff;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire tick = (tick_ff == 8'(TICK_DIV - 1));
  wire cmd_take = link.cmd_valid & link.cmd_ready;
  wire rsp_take = link.rsp_valid & link.rsp_ready;
  wire [7:0] src = prm_ff[IWC_P_SRC];
  wire [7:0] period = prm_ff[IWC_P_PERIOD];
  wire [4:0] maxsleep = prm_ff[IWC_P_MAXSLEEP][4:0];
  wire tmo_en = src[IWC_SRC_TIMEOUT];
  wire tag_en = src[IWC_SRC_TAG];
  wire [15:0] ent_word = {prm_ff[IWC_P_ENT_H], prm_ff[IWC_P_ENT_L]};
  wire [15:0] wake_word = {prm_ff[IWC_P_WAKE_H], prm_ff[IWC_P_WAKE_L]};
  wire [15:0] leave_word = {prm_ff[IWC_P_LEAVE_H], prm_ff[IWC_P_LEAVE_L]};
  wire in_wait = (state_ff == IWC_S_IDLE) || (state_ff == IWC_S_OSC) ||
    (state_ff == IWC_S_CONV) || (state_ff == IWC_S_BURST);
  wire pulse_hit = in_wait & src[IWC_SRC_PULSE] & ~link.wake_pulse_n;
  wire select_hit = in_wait & src[IWC_SRC_SELECT] & ~link.select_n;
  wire [15:0] span_first = 16'(IWC_TICKS_PER_UNIT * IWC_PERIOD_BIAS - 1);
  wire [15:0] unit_last = 16'(IWC_TICKS_PER_UNIT - 1);
  // level outside the threshold window means a tag loaded the antenna
  wire tag_hit = (state_ff == IWC_S_BURST) && (cnt_ff == 16'h0000) && tick &&
    ((8'(level_sample) < prm_ff[IWC_P_THR_LO]) || (8'(level_sample) > prm_ff[IWC_P_THR_HI]));
  wire last_trial = tmo_en && (trials_ff == 6'(maxsleep));
  wire idle_done = (state_ff == IWC_S_IDLE) && tick && (cnt_ff == 16'h0000) && (unit_ff == 8'h00);
  wire tmo_hit = idle_done & last_trial & ~tag_en;
  wire burst_end_tmo = (state_ff == IWC_S_BURST) && tick && (cnt_ff == 16'h0000) &&
    !tag_hit && last_trial;

  assign link.cmd_ready = (state_ff == IWC_S_CODE) || (state_ff == IWC_S_LEN) ||
    (state_ff == IWC_S_PARAM) || (state_ff == IWC_S_DRAIN && cnt_ff != 16'h0000);
  assign link.rsp_valid = (state_ff == IWC_S_R0) || (state_ff == IWC_S_R1) ||
    (state_ff == IWC_S_R2);
  assign link.rsp_data = (state_ff == IWC_S_R0) ? (len_bad_ff ? IWC_RES_ERR : IWC_RES_OK) :
    (state_ff == IWC_S_R1) ? (len_bad_ff ? IWC_ERR_LEN : IWC_RES_LEN) : rsp_src_ff;

  // ----------------------------------------------------------------
  // resource outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      resource_ctrl <= IWC_LEAVE_ALL;
      fast_osc_on <= 1'b1;
      conv_on <= 1'b0;
      carrier_on <= 1'b0;
      waiting <= 1'b0;
    end else begin
      resource_ctrl <= (state_ff == IWC_S_IDLE && entry_ff) ? ent_word :
        in_wait ? wake_word :
        (state_ff == IWC_S_PARAM) ? resource_ctrl : leave_word;
      fast_osc_on <= !in_wait || (state_ff != IWC_S_IDLE);
      conv_on <= (state_ff == IWC_S_CONV) || (state_ff == IWC_S_BURST);
      carrier_on <= (state_ff == IWC_S_BURST);
      waiting <= in_wait;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tick_ff <= 8'h00;
    end else begin
      tick_ff <= (tick || !in_wait) ? 8'h00 : tick_ff + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_ff <= IWC_S_CODE;
      idx_ff <= 4'h0;
      rsp_src_ff <= 8'h00;
      cnt_ff <= 16'h0000;
      trials_ff <= 6'h00;
      unit_ff <= 8'h00;
      len_bad_ff <= 1'b0;
      entry_ff <= 1'b0;
      for (int i = 0; i < IWC_NPARAM; i++) begin
        prm_ff[i] <= 8'h00;
      end
    end else begin
      case (state_ff)
        IWC_S_CODE: begin
          if (cmd_take && link.cmd_data == IWC_CMD_IDLE) begin
            state_ff <= IWC_S_LEN;
          end
        end
        IWC_S_LEN: begin
          if (cmd_take) begin
            idx_ff <= 4'h0;
            len_bad_ff <= (link.cmd_data != IWC_LEN_FULL);
            state_ff <= (link.cmd_data == IWC_LEN_FULL) ? IWC_S_PARAM : IWC_S_DRAIN;
            cnt_ff <= {8'h00, link.cmd_data};
          end
        end
        IWC_S_DRAIN: begin
          // a bad length still consumes its bytes so the link stays framed
          if (cnt_ff == 16'h0000) begin
            state_ff <= IWC_S_R0;
          end else if (cmd_take) begin
            cnt_ff <= cnt_ff - 16'h0001;
          end
        end
        IWC_S_PARAM: begin
          if (cmd_take) begin
            prm_ff[idx_ff] <= link.cmd_data;
            idx_ff <= idx_ff + 4'h1;
            if (idx_ff == IWC_P_MAXSLEEP) begin
              state_ff <= IWC_S_IDLE;
              cnt_ff <= span_first;
              unit_ff <= period;
              entry_ff <= 1'b1;
              trials_ff <= 6'h00;
            end
          end
        end
        IWC_S_IDLE: begin
          // double first unit, then period units: no 17-bit span count needed
          if (tick) begin
            entry_ff <= 1'b0;
            if (cnt_ff != 16'h0000) begin
              cnt_ff <= cnt_ff - 16'h0001;
            end else if (unit_ff != 8'h00) begin
              unit_ff <= unit_ff - 8'h01;
              cnt_ff <= unit_last;
            end else if (tmo_hit) begin
              rsp_src_ff <= IWC_SRC_TIMEOUT_CODE;
              state_ff <= IWC_S_R0;
            end else if (tag_en) begin
              cnt_ff <= {8'h00, prm_ff[IWC_P_OSC]};
              state_ff <= IWC_S_OSC;
            end else begin
              cnt_ff <= span_first;
              unit_ff <= period;
              trials_ff <= trials_ff + 6'h01;
            end
          end
        end
        IWC_S_OSC: begin
          if (tick) begin
            if (cnt_ff <= 16'h0001) begin
              cnt_ff <= {8'h00, prm_ff[IWC_P_CONV]};
              state_ff <= IWC_S_CONV;
            end else begin
              cnt_ff <= cnt_ff - 16'h0001;
            end
          end
        end
        IWC_S_CONV: begin
          if (tick) begin
            if (cnt_ff <= 16'h0001) begin
              cnt_ff <= {8'h00, prm_ff[IWC_P_SWING]};
              state_ff <= IWC_S_BURST;
            end else begin
              cnt_ff <= cnt_ff - 16'h0001;
            end
          end
        end
        IWC_S_BURST: begin
          if (tick) begin
            if (cnt_ff != 16'h0000) begin
              cnt_ff <= cnt_ff - 16'h0001;
            end else if (tag_hit) begin
              rsp_src_ff <= IWC_SRC_TAG_CODE;
              state_ff <= IWC_S_R0;
            end else if (burst_end_tmo) begin
              rsp_src_ff <= IWC_SRC_TIMEOUT_CODE;
              state_ff <= IWC_S_R0;
            end else begin
              trials_ff <= trials_ff + 6'h01;
              cnt_ff <= span_first;
              unit_ff <= period;
              state_ff <= IWC_S_IDLE;
            end
          end
        end
        IWC_S_R0: begin
          if (rsp_take) begin
            state_ff <= IWC_S_R1;
          end
        end
        IWC_S_R1: begin
          if (rsp_take) begin
            state_ff <= len_bad_ff ? IWC_S_CODE : IWC_S_R2;
          end
        end
        IWC_S_R2: begin
          if (rsp_take) begin
            len_bad_ff <= 1'b0;
            state_ff <= IWC_S_CODE;
          end
        end
        default: begin
          state_ff <= IWC_S_CODE;
        end
      endcase
      // external pulses win over timer events in the same cycle
      if (pulse_hit) begin
        rsp_src_ff <= IWC_SRC_PULSE_CODE;
        state_ff <= IWC_S_R0;
      end else if (select_hit) begin
        rsp_src_ff <= IWC_SRC_SELECT_CODE;
        state_ff <= IWC_S_R0;
      end
    end
  end
endmodule

// File: rtl/iwc_host.sv
// host end: serialises a low-power entry command and collects the wake reply
`timescale 1ns/1ps
module iwc_host
  import iwc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  iwc_link_if.host link,
  input wire logic start,
  input wire logic [7:0] src_mask,
  input wire logic [15:0] ent_word,
  input wire logic [15:0] wake_word,
  input wire logic [7:0] period,
  input wire logic [7:0] osc_start,
  input wire logic [7:0] conv_start,
  input wire logic [7:0] thr_lo,
  input wire logic [7:0] thr_hi,
  input wire logic [7:0] swing,
  input wire logic [7:0] maxsleep,
  input wire logic calib,
  input wire logic wake_pulse_req,
  input wire logic select_req,
  output logic busy,
  output logic done,
  output logic [7:0] result,
  output logic [7:0] wake_src
);
  import iwc_pkg::*;

  logic [4:0] pos_ff;
  logic [1:0] rpos_ff;
  logic sending_ff;
  logic [7:0] frame [16];

  // clamp into the legal range; calibration forces maxsleep to 1, which allows two trials
  wire [7:0] ms_fix = calib ? IWC_MAXSLEEP_CAL :
    (maxsleep == IWC_MAXSLEEP_MIN) ? 8'h01 :
    (maxsleep >= IWC_MAXSLEEP_MAX) ? 8'h1E : maxsleep;
  always_comb begin
    frame[0] = IWC_CMD_IDLE;
    frame[1] = IWC_LEN_FULL;
    frame[2] = src_mask;
    frame[3] = ent_word[7:0];
    frame[4] = ent_word[15:8];
    frame[5] = wake_word[7:0];
    frame[6] = wake_word[15:8];
    frame[7] = IWC_LEAVE_ALL[7:0];
    frame[8] = IWC_LEAVE_ALL[15:8];
    frame[9] = period;
    frame[10] = osc_start;
    frame[11] = conv_start;
    frame[12] = calib ? 8'h00 : thr_lo;
    frame[13] = thr_hi;
    frame[14] = swing;
    frame[15] = ms_fix;
  end

  assign link.cmd_valid = sending_ff;
  assign link.cmd_data = frame[pos_ff[3:0]];
  assign link.rsp_ready = 1'b1;
  assign busy = sending_ff;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pos_ff <= 5'h00;
      sending_ff <= 1'b0;
      rpos_ff <= 2'h0;
      done <= 1'b0;
      result <= 8'h00;
      wake_src <= 8'h00;
      link.wake_pulse_n <= 1'b1;
      link.select_n <= 1'b1;
    end else begin
      link.wake_pulse_n <= ~wake_pulse_req;
      link.select_n <= ~select_req;
      done <= 1'b0;
      if (start && !sending_ff) begin
        sending_ff <= 1'b1;
        pos_ff <= 5'h00;
      end else if (sending_ff && link.cmd_ready) begin
        pos_ff <= pos_ff + 5'h01;
        if (pos_ff == 5'h0F) begin
          sending_ff <= 1'b0;
        end
      end
      if (link.rsp_valid) begin
        case (rpos_ff)
          2'h0: begin
            result <= link.rsp_data;
            rpos_ff <= 2'h1;
          end
          2'h1: begin
            rpos_ff <= (result == IWC_RES_OK) ? 2'h2 : 2'h0;
            done <= (result != IWC_RES_OK);
          end
          default: begin
            wake_src <= link.rsp_data;
            rpos_ff <= 2'h0;
            done <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule

// File: bench/iwc_sva.sv
// checker: link-level timing of the low-power entry command
`timescale 1ns/1ps
module iwc_sva
  import iwc_pkg::*;
(
  input logic mclk,
  input logic rst_n,
  input logic [7:0] cmd_data,
  input logic cmd_valid,
  input logic cmd_ready,
  input logic [7:0] rsp_data,
  input logic rsp_valid,
  input logic rsp_ready,
  input logic wake_pulse_n,
  input logic select_n
);
  logic [3:0] pos_ff;
  logic [7:0] mask_ff;
  wire take = cmd_valid && cmd_ready;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // --------------------------------
  // command tracking
  // --------------------------------
  // stray first bytes do not advance, 16 bytes wrap back to 0
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pos_ff <= 4'h0;
      mask_ff <= 8'h00;
    end else if (take) begin
      pos_ff <= (pos_ff == 4'h0 && cmd_data != IWC_CMD_IDLE) ? 4'h0 : pos_ff + 4'h1;
      if (pos_ff == 4'h2) mask_ff <= cmd_data;
    end
  end
  // --------------------------------
  // properties
  // --------------------------------
  a_len_full: assert property (take && pos_ff == 4'h1 |-> cmd_data == IWC_LEN_FULL)
    else $error("length byte not full");
  a_wait_drops_ready: assert property (take && pos_ff == 4'hF |-> ##[1:3] !cmd_ready)
    else $error("ready stays up after last byte");
  a_no_early_reply: assert property (pos_ff != 4'h0 |-> !rsp_valid)
    else $error("reply inside a command");
  a_reply_blocks_cmd: assert property (rsp_valid |-> !cmd_ready)
    else $error("command taken during reply");
  a_reply_code: assert property ($rose(rsp_valid) |-> rsp_data == IWC_RES_OK)
    else $error("bad result code");
  a_reply_length: assert property ($rose(rsp_valid) |=> rsp_valid && rsp_data == IWC_RES_LEN)
    else $error("bad reply length");
  a_reply_three: assert property ($rose(rsp_valid) |-> rsp_valid [*3] ##1 !rsp_valid)
    else $error("reply not three bytes");
  a_source_enabled: assert property ($rose(rsp_valid) |-> ##2 $onehot(rsp_data) &&
    (rsp_data & mask_ff & 8'h1B) != 8'h00)
    else $error("wake source not enabled");
  a_pulse_wakes: assert property ($fell(wake_pulse_n) && !cmd_ready && !rsp_valid &&
    mask_ff[IWC_SRC_PULSE] |-> ##[1:3] rsp_valid)
    else $error("enabled pulse did not wake");
endmodule

// File: bench/idle_wakeup_command_tb.sv
// testbench: host and device joined on the link, plus a faulty host on a second link
`timescale 1ns/1ps
module idle_wakeup_command_tb;
  import iwc_pkg::*;
  logic mclk, rst_n, start, calib, wake_pulse_req, select_req, busy, done, car_q;
  logic [7:0] src_mask, period, osc_start, conv_start, thr_lo, thr_hi, swing, maxsleep;
  logic [7:0] result, wake_src;
  logic [15:0] ent_word, wake_word, resource_ctrl;
  logic [5:0] level_sample;
  logic fast_osc_on, conv_on, carrier_on, waiting;
  logic [7:0] cap [0:15];
  int err_count, tests_run, cpos, cyc, bursts, run, conv_run;
  iwc_link_if link();
  iwc_link_if flt_link();
  iwc_host iwc_host_inst (.mclk(mclk), .rst_n(rst_n), .link(link), .start(start),
    .src_mask(src_mask), .ent_word(ent_word), .wake_word(wake_word), .period(period),
    .osc_start(osc_start), .conv_start(conv_start), .thr_lo(thr_lo), .thr_hi(thr_hi),
    .swing(swing), .maxsleep(maxsleep), .calib(calib), .wake_pulse_req(wake_pulse_req),
    .select_req(select_req), .busy(busy), .done(done), .result(result), .wake_src(wake_src));
  // short tick keeps timeouts near a thousand cycles
  iwc_device #(.TICK_DIV(1)) iwc_device_inst (.mclk(mclk), .rst_n(rst_n), .link(link),
    .level_sample(level_sample), .resource_ctrl(resource_ctrl), .fast_osc_on(fast_osc_on),
    .conv_on(conv_on), .carrier_on(carrier_on), .waiting(waiting));
  iwc_device #(.TICK_DIV(1)) iwc_device_fault_inst (.mclk(mclk), .rst_n(rst_n),
    .link(flt_link), .level_sample(6'h00), .resource_ctrl(), .fast_osc_on(), .conv_on(),
    .carrier_on(), .waiting());
  iwc_sva iwc_sva_inst (.mclk(mclk), .rst_n(rst_n), .cmd_data(link.cmd_data),
    .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready), .rsp_data(link.rsp_data),
    .rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready),
    .wake_pulse_n(link.wake_pulse_n), .select_n(link.select_n));
  // --------------------------------
  // monitors
  // --------------------------------
  always @(posedge mclk) begin
    if (link.cmd_valid && link.cmd_ready) begin
      cap[cpos[3:0]] <= link.cmd_data;
      cpos <= cpos + 1;
    end
    if (carrier_on && !car_q) bursts <= bursts + 1;
    if (carrier_on) run <= run + 1;
    if (conv_on) conv_run <= conv_run + 1;
    car_q <= carrier_on;
  end
  // --------------------------------
  // tasks
  // --------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic send(input logic [7:0] m, input logic [15:0] e, input logic [15:0] w);
    int i;
    src_mask = m;
    ent_word = e;
    wake_word = w;
    cpos = 0;
    bursts = 0;
    run = 0;
    conv_run = 0;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    chk8({7'h00, busy}, 8'h01);
    for (i = 0; i < 200 && waiting !== 1'b1; i++) tick(1);
  endtask
  task automatic reply(input logic [7:0] src);
    for (cyc = 0; cyc < 4000 && done !== 1'b1; cyc++) tick(1);
    chk8(result, IWC_RES_OK);
    chk8(wake_src, src);
  endtask
  // faulty host keeps valid up between bytes, caller drops it
  task automatic put(input logic [7:0] b);
    int i;
    flt_link.cmd_data = b;
    flt_link.cmd_valid = 1'b1;
    // ready is read settled, before the edge that takes the byte
    for (i = 0; i < 50 && flt_link.cmd_ready !== 1'b1; i++) tick(1);
    tick(1);
  endtask
  task automatic getr(input logic [7:0] exp);
    int i;
    for (i = 0; i < 200 && flt_link.rsp_valid !== 1'b1; i++) tick(1);
    chk8(flt_link.rsp_data, exp);
    tick(1);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // --------------------------------
  // clock, watchdog, tests
  // --------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #300000;
    err_count++;
    end_sim();
  end
  initial begin
    rst_n = 1'b0;
    {start, calib, wake_pulse_req, select_req, car_q} = 5'h00;
    {period, osc_start, conv_start, swing, maxsleep} = {8'h00, 8'h04, 8'h04, 8'h08, 8'h01};
    {thr_lo, thr_hi, level_sample} = {8'h10, 8'h30, 6'h20};
    {src_mask, ent_word, wake_word} = {8'h00, 16'h0000, 16'h0000};
    {flt_link.cmd_valid, flt_link.cmd_data, flt_link.rsp_ready} = {1'b0, 8'h00, 1'b1};
    {flt_link.wake_pulse_n, flt_link.select_n} = 2'h3;
    tick(10);
    rst_n = 1'b1;
    send(8'h08, IWC_ENT_HIBERNATE, IWC_WAKE_HIBERNATE);
    chk16(resource_ctrl, IWC_ENT_HIBERNATE);
    chk8({7'h00, fast_osc_on}, 8'h00);
    chk8(cap[0], IWC_CMD_IDLE);
    chk8(cap[1], IWC_LEN_FULL);
    chk8(cap[2], 8'h08);
    chk8(cap[4], 8'h04);
    chk8(cap[8], 8'h18);
    wake_pulse_req = 1'b1;
    tick(3);
    wake_pulse_req = 1'b0;
    reply(IWC_SRC_PULSE_CODE);
    tick(2);
    chk16(resource_ctrl, IWC_LEAVE_ALL);
    $display("hibernate test done");
    send(8'h12, IWC_ENT_TAG, IWC_WAKE_TAG);
    tick(2);
    chk16(resource_ctrl, IWC_WAKE_TAG);
    wake_pulse_req = 1'b1;
    tick(4);
    wake_pulse_req = 1'b0;
    tick(4);
    chk8({7'h00, waiting}, 8'h01);
    select_req = 1'b1;
    tick(3);
    select_req = 1'b0;
    reply(IWC_SRC_SELECT_CODE);
    $display("select test done");
    maxsleep = 8'h00;
    send(8'h01, IWC_ENT_TAG, IWC_WAKE_SLEEP);
    chk8(cap[15], 8'h01);
    reply(IWC_SRC_TIMEOUT_CODE);
    // two spans of 256 * (0 + 2) ticks, then two reply cycles
    chk8({7'h00, cyc >= 1024 && cyc <= 1028}, 8'h01);
    $display("timeout test done");
    {calib, thr_hi, level_sample} = {1'b1, 8'h20, 6'h3F};
    send(8'h03, IWC_ENT_CALIB, IWC_WAKE_CALIB);
    chk8(cap[15], IWC_MAXSLEEP_CAL);
    chk8(cap[12], 8'h00);
    reply(IWC_SRC_TAG_CODE);
    chk8({7'h00, run >= 8 && run <= 10}, 8'h01);
    // converter settles 4 ticks, then stays on through the 9-tick burst
    chk8(conv_run[7:0], 8'h0D);
    {calib, thr_hi, level_sample, maxsleep} = {1'b0, 8'h30, 6'h20, 8'h02};
    $display("calibration test done");
    send(8'h03, IWC_ENT_TAG, IWC_WAKE_TAG);
    reply(IWC_SRC_TIMEOUT_CODE);
    chk8(bursts[7:0], 8'h03);
    $display("burst count test done");
    put(8'h55);
    flt_link.cmd_valid = 1'b0;
    tick(5);
    chk8({7'h00, flt_link.rsp_valid}, 8'h00);
    put(IWC_CMD_IDLE);
    put(8'h05);
    for (int i = 0; i < 5; i++) put(8'hA0 + 8'(i));
    flt_link.cmd_valid = 1'b0;
    flt_link.cmd_data = 8'h5B;
    getr(IWC_RES_ERR);
    getr(IWC_ERR_LEN);
    $display("fault link test done");
    end_sim();
  end
endmodule
